//--- logic/rpm_pkg.sv
// Package for the power management block: register map, field positions,
// reset values and timing constants.
// Assumes a 125 MHz system clock and an APB slave with 32-bit data.
package rpm_pkg;
  // Clock rate
  localparam longint ClkHz          = 125000000;
  // Register byte offsets
  localparam logic [7:0] CtrlOff    = 8'h00;
  localparam logic [7:0] StatOff    = 8'h04;
  localparam logic [7:0] TimeOff    = 8'h08;
  // Control register fields
  localparam int CtlEthBit          = 0;
  localparam int CtlUsbBit          = 1;
  localparam int CtlReducedBit      = 2;
  localparam int CtlSleepBit        = 3;
  localparam int CtlPanelReqBit     = 4;
  localparam int CtlIndDefBit       = 5;
  localparam logic [31:0] CtrlRst   = 32'h0000_0003;
  // Status register fields
  localparam int StIndBit           = 0;
  localparam int StPanelBit         = 1;
  localparam int StTimerBit         = 2;
  localparam int StSleepBit         = 3;
  localparam int StWakeLo           = 4;
  localparam int WakeW              = 4;        // Button, USB, clock event, counter
  // Timing: times in their own units, counts derived
  localparam int PanelTimeMin       = 5;
  localparam int IndTimeMin         = 5;
  localparam longint PanelTicks     = longint'(PanelTimeMin) * 60 * ClkHz;
  localparam logic [31:0] IndTimeRst = 32'h0000_012C; // Seconds, five minutes
  localparam longint SecTicks       = ClkHz;
  localparam int BlinkHalfSec       = 1;        // Unused; reduced-mode lamp is lit for the first eighth of each second
  localparam int DebounceMs         = 10;
  localparam int DebounceTicks      = int'(longint'(DebounceMs) * ClkHz / 1000);
  // Reduced clock: 12 MHz from 125 MHz is not integral; nearest divider
  localparam int ReducedMHz         = 12;
  localparam int ReducedDiv         = int'(ClkHz / (ReducedMHz * 1000000));
  localparam int SlowDiv            = 4096;
  localparam int CntRollW           = 16;       // 65536 pulses per rollover
  // Power mode states, Gray along normal -> reduced -> sleep
  typedef enum logic [1:0] {
    RPM_NORMAL  = 2'b00,
    RPM_REDUCED = 2'b01,
    RPM_SLEEP   = 2'b11
  } rpm_mode_t;
endpackage : rpm_pkg

//--- logic/rpm_debounce.sv
// Synchroniser and debouncer for one contact input, one pulse per press.
// Assumes an asynchronous active-high contact level and a single clock.
`timescale 1ns/1ns
`default_nettype none
module rpm_debounce #(
  parameter int Ticks = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic rawIn,
  output logic      pressPulse
);
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        stable;
    logic [31:0] cnt;
    logic        pulse;
  } rpm_deb_t;
  rpm_deb_t st_r, st_nxt;

  // Level must hold for the full window before it is accepted
  always_comb begin
    st_nxt       = st_r;
    st_nxt.s1    = rawIn;
    st_nxt.s2    = st_r.s1;
    st_nxt.pulse = 1'b0;
    if (st_r.s2 == st_r.stable) begin
      st_nxt.cnt = 32'h0000_0000;
    end else if (st_r.cnt == 32'(Ticks - 1)) begin
      st_nxt.cnt    = 32'h0000_0000;
      st_nxt.stable = st_r.s2;
      st_nxt.pulse  = st_r.s2;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign pressPulse = st_r.pulse;
endmodule : rpm_debounce
`default_nettype wire

//--- logic/rpm_power_mgmt.sv
// Power management top: panel supply, indicator power, port enables,
// reduced and sleep modes, wake sources, APB register file.
// Assumes APB master on clk; pins and counter inputs are asynchronous.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Indicator power on forces panel supply on.
// - Otherwise with timer idle, panel supply follows panel request bit.
// - Contact with indicator off and timer idle turns panel on, loads five-minute timer.
// - Contact while timer holds panel on switches panel off.
// - Panel power status reads one while panel supply is on.
// - Each button press inverts indicator power.
// - Indicator reverts to firmware default after firmware-set timeout.
// - Power lamp lit while indicator power enabled in normal mode.
// - Ethernet enable resets on; only firmware changes it.
// - USB enable resets on; only firmware changes it.
// - Reduced mode runs processor clock near 12 MHz.
// - Reduced mode blinks lamp once per second.
// - Sleep stops execution, drops 5 V rails, selects slow clock.
// - Counters and real-time clock keep running in sleep.
// - Reset, button press or USB attach wakes from sleep.
// - Real-time clock wake event wakes from sleep.
// - Any counter rollover after 65536 pulses wakes from sleep.
// - Lamp dark in sleep.
module rpm_power_mgmt #(
  parameter longint PanelTicksP = rpm_pkg::PanelTicks,
  parameter longint SecTicksP   = rpm_pkg::SecTicks,
  parameter int     DebTicksP   = rpm_pkg::DebounceTicks
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        toggleButton,
  input  wire logic        panelContact,
  input  wire logic        usbAttach,
  input  wire logic        rtcWake,
  input  wire logic [2:0]  counterIn,
  output logic             panelSupplyOn,
  output logic             powerLamp,
  output logic             ethEnable,
  output logic             usbEnable,
  output logic             cpuRun,
  output logic             rail5vOn,
  output logic             cpuClkEn
);
  localparam int W = rpm_pkg::WakeW;

  typedef struct packed {
    logic [31:0]           ctrl;
    logic [31:0]           indTime;
    rpm_pkg::rpm_mode_t    mode;
    logic                  ind;
    logic [31:0]           indSec;
    logic [31:0]           secCnt;
    logic                  secTick;
    logic [63:0]           panelCnt;
    logic                  panel;
    logic [W-1:0]          wake;
    logic [2:0][1:0]       cSync;
    logic [2:0]            cPrev;
    logic [2:0][15:0]      cCnt;
    logic [1:0]            uSync;
    logic [1:0]            rSync;
    logic                  uPrev;
    logic                  rPrev;
    logic [15:0]           clkCnt;
    logic                  clkEn;
    logic                  lamp;
    logic                  run;
    logic                  err;
    logic [31:0]           rdata;
    logic                  ready;
  } rpm_st_t;
  rpm_st_t st_r, st_nxt;

  logic btnPress;
  logic contactPress;

  // One debouncer per contact input
  rpm_debounce #(.Ticks(DebTicksP)) u_btn (
    .clk        (clk),
    .rst        (rst),
    .rawIn      (toggleButton),
    .pressPulse (btnPress)
  );
  rpm_debounce #(.Ticks(DebTicksP)) u_contact (
    .clk        (clk),
    .rst        (rst),
    .rawIn      (panelContact),
    .pressPulse (contactPress)
  );

  logic        apbAcc;
  logic        apbWr;
  logic [W-1:0] wakeNow;
  logic        anyWake;
  logic [15:0] divLim;
  logic        panelTimerOn;

  // Next-state logic for the whole block
  always_comb begin
    st_nxt       = st_r;
    apbAcc       = psel && penable && !st_r.ready;
    apbWr        = psel && penable && pwrite && st_r.ready; // Commits at the completing edge
    panelTimerOn = (st_r.panelCnt != 64'h0);
    st_nxt.ready = apbAcc;
    st_nxt.err   = apbAcc && paddr != rpm_pkg::CtrlOff && paddr != rpm_pkg::StatOff
                   && paddr != rpm_pkg::TimeOff;
    st_nxt.rdata = 32'h0000_0000;

    // Pin synchronisers; first stage read only by the second
    st_nxt.uSync = {st_r.uSync[0], usbAttach};
    st_nxt.rSync = {st_r.rSync[0], rtcWake};
    st_nxt.uPrev = st_r.uSync[1];
    st_nxt.rPrev = st_r.rSync[1];

    // Counters keep running in every mode, including sleep
    for (int i = 0; i < 3; i++) begin
      st_nxt.cSync[i] = {st_r.cSync[i][0], counterIn[i]};
      st_nxt.cPrev[i] = st_r.cSync[i][1];
      if (st_r.cSync[i][1] && !st_r.cPrev[i]) begin
        st_nxt.cCnt[i] = st_r.cCnt[i] + 16'h0001;
      end
    end

    // Wake sources, each a single-cycle event
    wakeNow[0] = btnPress;
    wakeNow[1] = st_r.uSync[1] && !st_r.uPrev;
    wakeNow[2] = st_r.rSync[1] && !st_r.rPrev;
    wakeNow[3] = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (st_r.cSync[i][1] && !st_r.cPrev[i] && (&st_r.cCnt[i])) begin
        wakeNow[3] = 1'b1;
      end
    end
    anyWake    = |wakeNow;

    // One-second tick
    st_nxt.secTick = 1'b0;
    if (st_r.secCnt == 32'(SecTicksP - 1)) begin
      st_nxt.secCnt  = 32'h0000_0000;
      st_nxt.secTick = 1'b1;
    end else begin
      st_nxt.secCnt = st_r.secCnt + 32'h0000_0001;
    end

    // Indicator power toggle and revert to default
    if (btnPress) begin
      st_nxt.ind    = !st_r.ind;
      st_nxt.indSec = st_r.indTime;
    end else if (st_r.secTick && st_r.indSec != 32'h0000_0000) begin
      st_nxt.indSec = st_r.indSec - 32'h0000_0001;
      if (st_r.indSec == 32'h0000_0001) begin
        st_nxt.ind = st_r.ctrl[rpm_pkg::CtlIndDefBit];
      end
    end

    // Panel supply timer
    if (st_r.ind) begin
      st_nxt.panelCnt = 64'h0;
    end else if (contactPress) begin
      if (panelTimerOn) st_nxt.panelCnt = 64'h0;
      else st_nxt.panelCnt = 64'(PanelTicksP);
    end else if (panelTimerOn) begin
      st_nxt.panelCnt = st_r.panelCnt - 64'h1;
    end
    // A contact that ends the timer also overrides the request bit
    if (st_r.ind) st_nxt.panel = 1'b1;
    else if (contactPress && panelTimerOn) st_nxt.panel = 1'b0;
    else if (contactPress) st_nxt.panel = 1'b1;
    else if (panelTimerOn) st_nxt.panel = 1'b1;
    else st_nxt.panel = st_r.ctrl[rpm_pkg::CtlPanelReqBit];

    // Register writes; firmware alone steers port enables and mode entry; wake events end sleep
    if (apbWr && paddr == rpm_pkg::CtrlOff) begin
      st_nxt.ctrl = pwdata;
    end
    if (apbWr && paddr == rpm_pkg::TimeOff) begin
      st_nxt.indTime = pwdata;
    end

    // Mode machine
    case (st_r.mode)
      rpm_pkg::RPM_NORMAL: begin
        if (st_r.ctrl[rpm_pkg::CtlSleepBit]) st_nxt.mode = rpm_pkg::RPM_SLEEP;
        else if (st_r.ctrl[rpm_pkg::CtlReducedBit]) st_nxt.mode = rpm_pkg::RPM_REDUCED;
      end
      rpm_pkg::RPM_REDUCED: begin
        if (st_r.ctrl[rpm_pkg::CtlSleepBit]) st_nxt.mode = rpm_pkg::RPM_SLEEP;
        else if (!st_r.ctrl[rpm_pkg::CtlReducedBit]) st_nxt.mode = rpm_pkg::RPM_NORMAL;
      end
      rpm_pkg::RPM_SLEEP: begin
        if (anyWake) begin
          st_nxt.mode = rpm_pkg::RPM_NORMAL;
          st_nxt.ctrl[rpm_pkg::CtlSleepBit] = 1'b0;
        end
      end
      default: st_nxt.mode = rpm_pkg::RPM_NORMAL;
    endcase
    st_nxt.run = (st_nxt.mode != rpm_pkg::RPM_SLEEP);
    // Sticky wake cause; a new event wins over a clear in the same cycle
    if (apbWr && paddr == rpm_pkg::StatOff) begin
      st_nxt.wake = st_r.wake & ~pwdata[rpm_pkg::StWakeLo +: W];
    end
    if (st_r.mode == rpm_pkg::RPM_SLEEP) st_nxt.wake = st_nxt.wake | wakeNow;

    // Processor clock enable divider
    case (st_r.mode)
      rpm_pkg::RPM_REDUCED: divLim = 16'(rpm_pkg::ReducedDiv - 1);
      rpm_pkg::RPM_SLEEP:   divLim = 16'(rpm_pkg::SlowDiv - 1);
      default:              divLim = 16'h0000;
    endcase
    if (st_r.clkCnt >= divLim) begin
      st_nxt.clkCnt = 16'h0000;
      st_nxt.clkEn  = 1'b1;
    end else begin
      st_nxt.clkCnt = st_r.clkCnt + 16'h0001;
      st_nxt.clkEn  = 1'b0;
    end

    // Lamp: steady when indicator on, blink in reduced, dark in sleep
    // Short flash at the start of every second, so one blink per second
    case (st_r.mode)
      rpm_pkg::RPM_SLEEP:   st_nxt.lamp = 1'b0;
      rpm_pkg::RPM_REDUCED: st_nxt.lamp = st_r.secCnt < 32'(SecTicksP / 8);
      default:              st_nxt.lamp = st_r.ind;
    endcase

    // Read mux; unmapped addresses read zero with an error
    if (apbAcc && !pwrite) begin
      case (paddr)
        rpm_pkg::CtrlOff: st_nxt.rdata = st_r.ctrl;
        rpm_pkg::TimeOff: st_nxt.rdata = st_r.indTime;
        rpm_pkg::StatOff: begin
          st_nxt.rdata[rpm_pkg::StIndBit]   = st_r.ind;
          st_nxt.rdata[rpm_pkg::StPanelBit] = st_r.panel;
          st_nxt.rdata[rpm_pkg::StTimerBit] = panelTimerOn;
          st_nxt.rdata[rpm_pkg::StSleepBit] = (st_r.mode == rpm_pkg::RPM_SLEEP);
          st_nxt.rdata[rpm_pkg::StWakeLo +: W] = st_r.wake;
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Whole state in one register; the non-zero reset values and the mode are named
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r         <= '0;
      st_r.ctrl    <= rpm_pkg::CtrlRst;
      st_r.indTime <= rpm_pkg::IndTimeRst;
      st_r.mode    <= rpm_pkg::RPM_NORMAL;
      st_r.run     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata        = st_r.rdata;
  assign pready        = st_r.ready;
  assign pslverr       = st_r.err;
  assign panelSupplyOn = st_r.panel;
  assign powerLamp     = st_r.lamp;
  assign ethEnable     = st_r.ctrl[rpm_pkg::CtlEthBit];
  assign usbEnable     = st_r.ctrl[rpm_pkg::CtlUsbBit];
  assign cpuRun        = st_r.run;
  assign rail5vOn      = st_r.run;
  assign cpuClkEn      = st_r.clkEn;

  // Indicator on forces panel supply one cycle later
  ind_panel_a: assert property (@(posedge clk) disable iff (rst)
    st_r.ind |=> panelSupplyOn) else $error("panel off while indicator on");
  // Request bit followed when indicator off and timer idle
  req_follow_a: assert property (@(posedge clk) disable iff (rst)
    (!st_r.ind && !contactPress && st_r.panelCnt == 64'h0)
    |=> panelSupplyOn == $past(st_r.ctrl[rpm_pkg::CtlPanelReqBit]))
    else $error("panel ignores request");
  // Contact with idle timer turns panel on
  contact_on_a: assert property (@(posedge clk) disable iff (rst)
    (contactPress && !st_r.ind && st_r.panelCnt == 64'h0)
    |=> panelSupplyOn && st_r.panelCnt != 64'h0)
    else $error("contact did not start panel");
  // Contact with running timer turns panel off
  contact_off_a: assert property (@(posedge clk) disable iff (rst)
    (contactPress && !st_r.ind && st_r.panelCnt != 64'h0) |=> !panelSupplyOn)
    else $error("contact did not stop panel");
  // Button toggles indicator
  btn_toggle_a: assert property (@(posedge clk) disable iff (rst)
    btnPress |=> st_r.ind != $past(st_r.ind)) else $error("button no toggle");
  // Lamp dark two cycles into sleep
  sleep_lamp_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.mode == rpm_pkg::RPM_SLEEP) ##1 (st_r.mode == rpm_pkg::RPM_SLEEP) |-> !powerLamp)
    else $error("lamp lit in sleep");
  // Wake leaves sleep next cycle
  wake_exit_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.mode == rpm_pkg::RPM_SLEEP && anyWake) |=> cpuRun && rail5vOn)
    else $error("no wake from sleep");
  // Normal mode lamp tracks indicator
  lamp_ind_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.mode == rpm_pkg::RPM_NORMAL) ##1 (st_r.mode == rpm_pkg::RPM_NORMAL)
    |-> powerLamp == $past(st_r.ind)) else $error("lamp not tracking");
endmodule : rpm_power_mgmt
`default_nettype wire

//--- verif/rpm_panel_model.sv
// Model of the outside contacts: indicator push-button and panel contact.
// Assumes clk is the system clock; callers enter press just after an edge.
`timescale 1ns/1ns
`default_nettype none
module rpm_panel_model #(
  parameter int HoldP = 9
) (
  input  wire logic clk,
  output logic      toggleButton,
  output logic      panelContact
);
  // Both contacts open at time zero
  initial begin
    toggleButton = 1'b0;
    panelContact = 1'b0;
  end

  // One clean closure; held well past the debounce time so it counts once
  task automatic press(input bit contact);
    if (contact) begin
      panelContact <= 1'b1;
    end else begin
      toggleButton <= 1'b1;
    end
    repeat (HoldP) @(posedge clk);
    panelContact <= 1'b0;
    toggleButton <= 1'b0;
    repeat (HoldP) @(posedge clk); // Open long enough to debounce too
  endtask : press
endmodule : rpm_panel_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the power management block, driven over APB.
// Assumes shortened timer parameters; counter inputs pulse only a few times.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int DebT = 3;
  localparam int SecT = 20;
  localparam int PanT = 200;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        usbAttach = 1'b0;
  logic        rtcWake = 1'b0;
  logic [2:0]  counterIn = 3'h0;
  logic        lampPrev;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        toggleButton;
  logic        panelContact;
  logic        panelSupplyOn;
  logic        powerLamp;
  logic        ethEnable;
  logic        usbEnable;
  logic        cpuRun;
  logic        rail5vOn;
  logic        cpuClkEn;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          cnt;
  int          blinks;

  always #4 clk = ~clk;

  rpm_power_mgmt #(.PanelTicksP(PanT), .SecTicksP(SecT), .DebTicksP(DebT)) dut_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .toggleButton(toggleButton), .panelContact(panelContact),
    .usbAttach(usbAttach), .rtcWake(rtcWake), .counterIn(counterIn),
    .panelSupplyOn(panelSupplyOn), .powerLamp(powerLamp), .ethEnable(ethEnable),
    .usbEnable(usbEnable), .cpuRun(cpuRun), .rail5vOn(rail5vOn), .cpuClkEn(cpuClkEn)
  );

  rpm_panel_model #(.HoldP(DebT + 6)) pm_u (
    .clk(clk), .toggleButton(toggleButton), .panelContact(panelContact)
  );

  // Count, then report any difference at once
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // APB transfer held until pready is seen high at an edge; only the hang guard ends a wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Hang guard, well above the thousand or so cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values, firmware-only port enables, unmapped access
    apb(1'b0, rpm_pkg::CtrlOff, 32'h0);
    chk("ctrl reset", rpm_pkg::CtrlRst, rd);
    chk("port enables", 32'h3, {30'h0, usbEnable, ethEnable});
    apb(1'b0, rpm_pkg::TimeOff, 32'h0);
    chk("time reset", rpm_pkg::IndTimeRst, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped read", 32'h1, {rd[30:0], err});
    apb(1'b1, rpm_pkg::CtrlOff, 32'h0);
    tick(2);
    chk("ports off", 32'h0, {30'h0, usbEnable, ethEnable});
    // Mid-run reset must bring both port enables back on
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    chk("enables after reset", 32'h3, {30'h0, usbEnable, ethEnable});
    apb(1'b1, rpm_pkg::CtrlOff, 32'h3);
    $display("test reset and enables done");
    // Panel supply follows the request bit, status mirrors it
    for (int v = 1; v >= 0; v--) begin
      apb(1'b1, rpm_pkg::CtrlOff, 32'h3 | (v << rpm_pkg::CtlPanelReqBit));
      tick(3);
      chk("panel request", v, panelSupplyOn);
      apb(1'b0, rpm_pkg::StatOff, 32'h0);
      chk("panel status", v, rd[rpm_pkg::StPanelBit]);
    end
    $display("test panel request done");
    // Contact starts the timer, it runs out; a contact under timer turns off
    pm_u.press(1'b1);
    chk("contact on", 32'h1, panelSupplyOn);
    apb(1'b0, rpm_pkg::StatOff, 32'h0);
    chk("timer running", 32'h1, rd[rpm_pkg::StTimerBit]);
    tick(PanT + 20);
    chk("timer expiry", 32'h0, panelSupplyOn);
    pm_u.press(1'b1);
    chk("contact on again", 32'h1, panelSupplyOn);
    pm_u.press(1'b1);
    chk("contact off", 32'h0, panelSupplyOn);
    $display("test panel contact done");
    // Button toggles indicator power; lamp and panel supply follow
    pm_u.press(1'b0);
    chk("lamp on", 32'h1, powerLamp);
    chk("panel forced", 32'h1, panelSupplyOn);
    pm_u.press(1'b0);
    chk("lamp off", 32'h0, powerLamp);
    $display("test button done");
    // Revert to either default after a four-second timeout
    apb(1'b1, rpm_pkg::TimeOff, 32'h4);
    for (int dv = 0; dv < 2; dv++) begin
      apb(1'b1, rpm_pkg::CtrlOff, 32'h3 | (dv << rpm_pkg::CtlIndDefBit));
      repeat (dv + 1) pm_u.press(1'b0);
      chk("before revert", 32'(1 - dv), powerLamp);
      tick(4 * SecT + 20);
      chk("after revert", 32'(dv), powerLamp);
    end
    apb(1'b1, rpm_pkg::CtrlOff, 32'h3);
    pm_u.press(1'b0);
    $display("test revert done");
    // Clock enable rate in normal and reduced mode
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, rpm_pkg::CtrlOff, 32'h3 | (m << rpm_pkg::CtlReducedBit));
      tick(30);
      cnt = 0;
      blinks = 0;
      lampPrev = powerLamp;
      repeat (100) begin
        @(posedge clk);
        cnt += int'(cpuClkEn);
        blinks += int'(powerLamp && !lampPrev);
        lampPrev = powerLamp;
      end
      chk("clock enables", m ? 100 / rpm_pkg::ReducedDiv : 100, 32'(cnt));
      chk("lamp blinks", m ? 100 / SecT : 0, 32'(blinks));
    end
    $display("test reduced mode done");
    // Sleep, then three wake sources in turn: button, USB attach, clock event
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, rpm_pkg::CtrlOff, 32'h3 | (1 << rpm_pkg::CtlSleepBit));
      tick(5);
      chk("asleep", 32'h0, {28'h0, cpuClkEn, cpuRun, rail5vOn, powerLamp});
      if (s == 0) begin
        // Three pulses on every counter input; far from rollover, so no wake
        repeat (3) begin
          counterIn <= 3'h7;
          tick(2);
          counterIn <= 3'h0;
          tick(2);
        end
        tick(4);
        chk("counts in sleep", 32'h0003_0303, {8'h00, dut_u.st_r.cCnt[2][7:0],
            dut_u.st_r.cCnt[1][7:0], dut_u.st_r.cCnt[0][7:0]});
        chk("still asleep", 32'h0, {31'h0, cpuRun});
        pm_u.press(1'b0);
      end else if (s == 1) begin
        usbAttach <= 1'b1;
      end else begin
        rtcWake <= 1'b1;
      end
      tick(20);
      chk("awake", 32'h3, {30'h0, cpuRun, rail5vOn});
      apb(1'b0, rpm_pkg::StatOff, 32'h0);
      chk("wake cause", 32'h1 << s, {28'h0, rd[7:4]});
      apb(1'b1, rpm_pkg::StatOff, 32'hF0);
      usbAttach <= 1'b0;
      rtcWake   <= 1'b0;
    end
    $display("test sleep done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
